// ### include/bridge_pwm_pkg.sv
// constants, register map and field layout of the bridge pwm output stage
// assumes a 32-bit apb master and a 125 MHz pclk taken as the oscillator clock
package bridge_pwm_pkg;
   localparam int          DATA_W       = 32;
   localparam int          ADDR_W       = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_MODE     = 8'h00;
   localparam logic [7:0]  OFS_DUTY     = 8'h04;
   localparam logic [7:0]  OFS_PERIOD   = 8'h08;
   localparam logic [7:0]  OFS_PRESC    = 8'h0C;
   localparam logic [7:0]  OFS_DBCFG    = 8'h10;
   localparam logic [7:0]  OFS_STEER    = 8'h14;
   localparam logic [7:0]  OFS_SDCFG    = 8'h18;
   localparam logic [7:0]  OFS_STATUS   = 8'h1C;
   // reset values
   localparam logic [7:0]  RST_MODE     = 8'h00;
   localparam logic [7:0]  RST_DUTY     = 8'h00;
   localparam logic [7:0]  RST_PERIOD   = 8'hFF;
   localparam logic [1:0]  RST_PRESC    = 2'h0;
   localparam logic [7:0]  RST_DBCFG    = 8'h00;
   localparam logic [4:0]  RST_STEER    = 5'h01;
   localparam logic [7:0]  RST_SDCFG    = 8'h00;
   // field positions
   localparam int          DIR_BIT      = 7;
   localparam int          SYNC_BIT     = 4;
   localparam int          RESTART_BIT  = 7;
   localparam int          SD_FLAG_BIT  = 7;
   localparam int          SD_SRC_BIT   = 6;
   localparam int          STAT_TMR_LSB = 16;
   // output configurations
   typedef enum logic [1:0] {
      CFG_SINGLE   = 2'b00,
      CFG_FULL_FWD = 2'b01,
      CFG_HALF     = 2'b10,
      CFG_FULL_REV = 2'b11
   } out_cfg_t;
   localparam logic [1:0]  PWM_MODE_HI  = 2'b11;
   // prescaler terminal counts for 1, 4 and 16
   localparam logic [3:0]  PRE_MAX_1    = 4'h0;
   localparam logic [3:0]  PRE_MAX_4    = 4'h3;
   localparam logic [3:0]  PRE_MAX_16   = 4'hF;
   localparam logic [1:0]  SUB_LAST     = 2'h3;
   // shutdown pin states
   localparam logic [1:0]  SD_LOW       = 2'b00;
   localparam logic [1:0]  SD_HIGH      = 2'b01;
   // dead band counts instruction cycles of four oscillator periods
   localparam int          TCY_SHIFT    = 2;
endpackage

// ### design/bridge_pwm_output_stage.sv
// enhanced pwm output stage: time base, duty, dead band, bridge and steering outputs
// assumes an apb master on pclk; shutdown_in is synchronous to pclk
// Notes on behaviour
// - control settings sit in shadow copies, loaded to active at period boundary
// - dead band setting loads at duty boundary or period boundary, whichever first
// - enhanced waveform starts at next timer reset, registered pins follow one pclk late
// - duty beyond period leaves the pwm pins unchanged
// - half-bridge drives pwm on A and its complement on B
// - half-bridge delays each rise to active by dead band count instruction cycles
// - dead band above duty keeps that half-bridge output inactive all cycle
// - full forward holds A active, modulates D, two outputs active
// - full reverse holds C active and modulates B
// - direction bit 7 selects forward or reverse, applied next pwm cycle
// - on direction change B and D go inactive, A and C switch early
// - early switch happens four timer counts, four oscillator periods times prescale
// - full-bridge mode inserts no dead band
// - steering only in pwm mode with single output configuration
// - reset routes the pwm signal to output A only
// - steering sends the pwm to each enabled pin, others stay port pins
// - low two mode bits choose output polarity while steering
// - shutdown acts in steering too, only on pins with pwm enabled
// - output configuration bits pick single, half, full forward, full reverse
// - at period end timer clears, pin goes active unless duty is zero or beyond period, and duty latches
// - steering sync bit set applies steering at next period, else at once
`timescale 1ns/1ps
`default_nettype none
module bridge_pwm_output_stage
   import bridge_pwm_pkg::*;
(
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [bridge_pwm_pkg::ADDR_W-1:0] paddr,
   input  wire logic [bridge_pwm_pkg::DATA_W-1:0] pwdata,
   output logic      [bridge_pwm_pkg::DATA_W-1:0] prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  wire logic                             shutdown_in,
   output logic                                  bridge_out_a,
   output logic                                  bridge_out_b,
   output logic                                  bridge_out_c,
   output logic                                  bridge_out_d,
   output logic                                  bridge_oe_a,
   output logic                                  bridge_oe_b,
   output logic                                  bridge_oe_c,
   output logic                                  bridge_oe_d
);
   import bridge_pwm_pkg::*;

   typedef struct packed {
      logic [7:0]  unit_mode_control;
      logic [7:0]  duty_high_bits;
      logic [7:0]  period_value;
      logic [1:0]  timer_prescale_sel;
      logic [7:0]  dead_band_config;
      logic [4:0]  steering_control;
      logic [7:0]  shutdown_config;
      logic [3:0]  act_mode;
      logic [1:0]  act_cfg;
      logic [9:0]  act_duty;
      logic [7:0]  act_period;
      logic [1:0]  act_presc;
      logic [6:0]  act_db;
      logic [3:0]  act_steer;
      logic [9:0]  period_timer;
      logic [3:0]  pre;
      logic        run;
      logic        raw;
      logic [8:0]  cnt_a;
      logic [8:0]  cnt_b;
      logic [3:0]  out;
      logic [3:0]  oe;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic       tick;
   logic       boundary;
   logic       duty_match;
   logic       early;
   logic       pwm_en;
   logic       full;
   logic       wr;
   logic       rd_ok;
   logic [3:0] pre_max;
   logic [9:0] tmr_nxt;
   logic [9:0] sw_duty;
   logic [9:0] sw_top;
   logic [8:0] db_target;
   logic       db_a;
   logic       db_b;
   logic [3:0] lv;
   logic [3:0] en;
   logic [3:0] inv;
   logic [3:0] pin;
   logic [31:0] rdata;

   always_comb
   begin
      case (s_q.act_presc)
         2'b00:   pre_max = PRE_MAX_1;
         2'b01:   pre_max = PRE_MAX_4;
         default: pre_max = PRE_MAX_16;
      endcase
      tick       = (s_q.pre == pre_max);
      tmr_nxt    = 10'(s_q.period_timer + 10'h001);
      boundary   = tick && (s_q.period_timer[9:2] == s_q.act_period)
                   && (s_q.period_timer[1:0] == SUB_LAST);
      duty_match = tick && !boundary && (tmr_nxt == s_q.act_duty);
      sw_duty    = {s_q.duty_high_bits, s_q.unit_mode_control[5:4]};
      sw_top     = {s_q.period_value, SUB_LAST};
      pwm_en     = (s_q.unit_mode_control[3:2] == PWM_MODE_HI);
      full       = (s_q.act_cfg == CFG_FULL_FWD) || (s_q.act_cfg == CFG_FULL_REV);
      // last four timer counts before the boundary span four oscillator periods times prescale
      early      = s_q.run && full && (s_q.period_timer[9:2] == s_q.act_period)
                   && (s_q.unit_mode_control[DIR_BIT] != s_q.act_cfg[1])
                   && s_q.unit_mode_control[6];
      db_target  = 9'(s_q.act_db) << TCY_SHIFT;
      db_a       = s_q.raw && (s_q.cnt_a >= db_target);
      db_b       = !s_q.raw && (s_q.cnt_b >= db_target);
      rd_ok      = 1'b1;
      case (paddr)
         OFS_MODE:   rdata = {24'h000000, s_q.unit_mode_control};
         OFS_DUTY:   rdata = {24'h000000, s_q.duty_high_bits};
         OFS_PERIOD: rdata = {24'h000000, s_q.period_value};
         OFS_PRESC:  rdata = {30'h00000000, s_q.timer_prescale_sel};
         OFS_DBCFG:  rdata = {24'h000000, s_q.dead_band_config};
         OFS_STEER:  rdata = {27'h0000000, s_q.steering_control};
         OFS_SDCFG:  rdata = {24'h000000, s_q.shutdown_config};
         OFS_STATUS: rdata = {6'h00, s_q.period_timer, 6'h00, s_q.raw, s_q.run,
                              s_q.oe, s_q.out};
         default:
         begin
            rdata = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
      wr = psel && penable && s_q.pready && pwrite && rd_ok;
   end

   always_comb
   begin
      s_d = s_q;
      // bus: one wait state, answer registered
      s_d.pready  = psel && penable && !s_q.pready;
      s_d.pslverr = psel && penable && !s_q.pready && !rd_ok;
      s_d.prdata  = (psel && penable && !s_q.pready && !pwrite) ? rdata : 32'h00000000;
      if (wr)
      begin
         case (paddr)
            OFS_MODE:   s_d.unit_mode_control  = pwdata[7:0];
            OFS_DUTY:   s_d.duty_high_bits     = pwdata[7:0];
            OFS_PERIOD: s_d.period_value       = pwdata[7:0];
            OFS_PRESC:  s_d.timer_prescale_sel = pwdata[1:0];
            OFS_DBCFG:  s_d.dead_band_config   = pwdata[7:0];
            OFS_STEER:  s_d.steering_control   = pwdata[4:0];
            OFS_SDCFG:  s_d.shutdown_config    = pwdata[7:0];
            default:    s_d.unit_mode_control  = s_q.unit_mode_control;
         endcase
      end
      // hardware set of the shutdown flag wins over a software clear
      if (s_q.shutdown_config[SD_SRC_BIT] && shutdown_in)
         s_d.shutdown_config[SD_FLAG_BIT] = 1'b1;
      else if (s_q.dead_band_config[RESTART_BIT] && !shutdown_in)
         s_d.shutdown_config[SD_FLAG_BIT] = 1'b0;

      // time base
      s_d.pre = tick ? 4'h0 : 4'(s_q.pre + 4'h1);
      if (tick)
         s_d.period_timer = boundary ? 10'h000 : tmr_nxt;
      if (boundary)
      begin
         // shadow to active here, dead band also at duty match, so a mid-period write cannot glitch a pin
         s_d.act_mode   = s_q.unit_mode_control[3:0];
         s_d.act_cfg    = s_q.unit_mode_control[7:6];
         s_d.act_duty   = sw_duty;
         s_d.act_period = s_q.period_value;
         s_d.act_presc  = s_q.timer_prescale_sel;
         s_d.act_db     = s_q.dead_band_config[6:0];
         s_d.run        = pwm_en;
         if (s_q.steering_control[SYNC_BIT])
            s_d.act_steer = s_q.steering_control[3:0];
         // an over-long duty never toggles the pin
         if (sw_duty <= sw_top)
            s_d.raw = pwm_en && (sw_duty != 10'h000);
      end
      else if (duty_match)
      begin
         s_d.raw    = 1'b0;
         s_d.act_db = s_q.dead_band_config[6:0];
      end
      if (!pwm_en)
      begin
         s_d.run = 1'b0;
         s_d.raw = 1'b0;
      end
      if (!s_q.steering_control[SYNC_BIT])
         s_d.act_steer = s_q.steering_control[3:0];

      // dead band counters measure instruction cycles in pclk periods
      s_d.cnt_a = (s_q.raw && s_q.cnt_a < db_target) ? 9'(s_q.cnt_a + 9'h001)
                  : (s_q.raw ? s_q.cnt_a : 9'h000);
      s_d.cnt_b = (!s_q.raw && s_q.run && s_q.cnt_b < db_target)
                  ? 9'(s_q.cnt_b + 9'h001)
                  : ((!s_q.raw && s_q.run) ? s_q.cnt_b : 9'h000);

      // logical levels per pin, bit 0 = A .. bit 3 = D
      lv = 4'h0;
      en = 4'h0;
      if (s_q.act_mode[3:2] == PWM_MODE_HI)
      begin
         case (out_cfg_t'(s_q.act_cfg))
            CFG_SINGLE:
            begin
               en = s_q.act_steer;
               lv = {4{s_q.raw && s_q.run}} & s_q.act_steer;
            end
            CFG_HALF:
            begin
               en = 4'h3;
               lv = {2'b00, db_b && s_q.run, db_a && s_q.run};
            end
            CFG_FULL_FWD:
            begin
               en = 4'hF;
               // no dead band: raw goes straight to the modulated pin
               lv = early ? 4'h4 : {s_q.raw, 2'b00, s_q.run};
            end
            default:
            begin
               en = 4'hF;
               // reverse mirrors forward: C held, B modulated
               lv = early ? 4'h1 : {1'b0, s_q.run, s_q.raw, 1'b0};
            end
         endcase
      end
      inv = {s_q.act_mode[0], s_q.act_mode[1], s_q.act_mode[0], s_q.act_mode[1]};
      pin = lv ^ inv;
      s_d.oe = en;
      for (int i = 0; i < 4; i++)
      begin
         s_d.out[i] = en[i] ? pin[i] : 1'b0;
         // shutdown only reaches pins that carry pwm
         if (en[i] && s_q.shutdown_config[SD_FLAG_BIT])
         begin
            case (i[0] ? s_q.shutdown_config[1:0] : s_q.shutdown_config[3:2])
               SD_LOW:  s_d.out[i] = 1'b0;
               SD_HIGH: s_d.out[i] = 1'b1;
               default:
               begin
                  s_d.out[i] = 1'b0;
                  s_d.oe[i]  = 1'b0;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q                    <= '0;
         s_q.unit_mode_control  <= RST_MODE;
         s_q.duty_high_bits     <= RST_DUTY;
         s_q.period_value       <= RST_PERIOD;
         s_q.timer_prescale_sel <= RST_PRESC;
         s_q.dead_band_config   <= RST_DBCFG;
         s_q.steering_control   <= RST_STEER;
         s_q.shutdown_config    <= RST_SDCFG;
         s_q.act_period         <= RST_PERIOD;
         s_q.act_steer          <= RST_STEER[3:0];
      end
      else
         s_q <= s_d;
   end

   assign prdata       = s_q.prdata;
   assign pready       = s_q.pready;
   assign pslverr      = s_q.pslverr;
   assign bridge_out_a = s_q.out[0];
   assign bridge_out_b = s_q.out[1];
   assign bridge_out_c = s_q.out[2];
   assign bridge_out_d = s_q.out[3];
   assign bridge_oe_a  = s_q.oe[0];
   assign bridge_oe_b  = s_q.oe[1];
   assign bridge_oe_c  = s_q.oe[2];
   assign bridge_oe_d  = s_q.oe[3];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   bus_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer missing after one wait state");
   timer_wrap_a: assert property (boundary |=> s_q.period_timer == 10'h000)
      else $error("timer did not clear at period end");
   shadow_hold_a: assert property (!boundary |=> $stable(s_q.act_period)
                                   && $stable(s_q.act_cfg))
      else $error("active settings changed away from boundary");
   db_load_a: assert property (!boundary && !duty_match |=> $stable(s_q.act_db))
      else $error("dead band loaded at wrong time");
   start_late_a: assert property ($rose(s_q.run) |-> $past(boundary))
      else $error("waveform started away from timer reset");
   over_duty_a: assert property (boundary && sw_duty > sw_top && pwm_en
                                 |=> s_q.raw == $past(s_q.raw))
      else $error("pin toggled with duty above period");
   db_hold_a: assert property (s_q.act_cfg == CFG_HALF && pwm_en && s_q.raw
                               && s_q.cnt_a < db_target
                               && !s_q.shutdown_config[SD_FLAG_BIT]
                               |=> bridge_out_a == $past(s_q.act_mode[1]))
      else $error("half-bridge output rose inside dead band");
   dir_early_a: assert property (early && !s_q.shutdown_config[SD_FLAG_BIT]
                                 && s_q.act_mode[3:2] == PWM_MODE_HI
                                 |=> bridge_out_b == $past(s_q.act_mode[0])
                                 && bridge_out_d == $past(s_q.act_mode[0]))
      else $error("modulated outputs active during direction change");
   fwd_unused_a: assert property (s_q.act_cfg == CFG_FULL_FWD && !early
                                  && s_q.act_mode[3:2] == PWM_MODE_HI
                                  && !s_q.shutdown_config[SD_FLAG_BIT]
                                  |=> bridge_out_b == $past(s_q.act_mode[0])
                                  && bridge_out_c == $past(s_q.act_mode[1]))
      else $error("unused full-bridge output not inactive");
   steer_off_a: assert property (s_q.act_cfg == CFG_SINGLE && !s_q.act_steer[1]
                                 |=> !bridge_oe_b)
      else $error("disabled steered pin still driven");
   half_excl_a: assert property (s_q.act_cfg == CFG_HALF && s_q.act_mode == {PWM_MODE_HI, 2'b00}
                                 && !s_q.shutdown_config[SD_FLAG_BIT]
                                 |=> !(bridge_out_a && bridge_out_b))
      else $error("half-bridge outputs active together");

   half_cov_c: cover property (s_q.act_cfg == CFG_HALF && s_q.run ##[1:300] bridge_oe_b);
   dir_cov_c:  cover property (early ##1 boundary);
   sd_cov_c:   cover property ($rose(s_q.shutdown_config[SD_FLAG_BIT]));
   fwd_cov_c:  cover property (s_q.act_cfg == CFG_FULL_FWD && s_q.run ##1 bridge_out_d);
endmodule // bridge_pwm_output_stage
`default_nettype wire

// ### testbench/gate_driver_model.sv
// gate driver inputs of a two-leg power bridge fed by the pwm output stage
// assumes active-high drive levels; legs are a/b and c/d
`timescale 1ns/1ps
`default_nettype none
module gate_driver_model (
   input  wire logic [3:0] drv,
   input  wire logic [3:0] en,
   output logic      [3:0] gate,
   output logic            shoot
);
   // a released gate input is pulled down, so its switch is off
   assign gate  = drv & en;
   // both switches of one leg on shorts the supply
   assign shoot = (gate[0] & gate[1]) | (gate[2] & gate[3]);
endmodule // gate_driver_model
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the bridge pwm output stage
// assumes the gate driver model; the apb master lives in this file
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bridge_pwm_pkg::*;
   logic        pclk        = 1'b0;
   logic        presetn     = 1'b0;
   logic        psel        = 1'b0;
   logic        penable     = 1'b0;
   logic        pwrite      = 1'b0;
   logic [7:0]  paddr       = 8'h00;
   logic [31:0] pwdata      = 32'h0;
   logic        shutdown_in = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  drv;
   logic [3:0]  en;
   logic [3:0]  gate;
   logic        shoot;
   logic [31:0] rd;
   logic        err;
   int          fails       = 0;
   int          checks_done = 0;
   int          cyc         = 0;
   int          hc [4];
   int          tg;
   int          sh;

   always #4 pclk = ~pclk;

   bridge_pwm_output_stage i_bridge_pwm_output_stage (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .shutdown_in(shutdown_in),
      .bridge_out_a(drv[0]), .bridge_out_b(drv[1]),
      .bridge_out_c(drv[2]), .bridge_out_d(drv[3]),
      .bridge_oe_a(en[0]), .bridge_oe_b(en[1]),
      .bridge_oe_c(en[2]), .bridge_oe_d(en[3])
   );

   gate_driver_model i_gate_driver_model (
      .drv(drv), .en(en), .gate(gate), .shoot(shoot)
   );

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         fails++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      checks_done++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
      end
   endtask

   // holds the request until pready is seen high at a rising edge or 16 edges pass
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      check({31'h0, pready}, 32'h1, "pready");
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // counts over whole periods, so the phase of the start does not matter
   task automatic measure(input int n);
      logic last;
      hc   = '{0, 0, 0, 0};
      tg   = 0;
      sh   = 0;
      last = drv[0];
      repeat (n)
      begin
         @(posedge pclk);
         for (int i = 0; i < 4; i++)
            hc[i] += int'(drv[i] === 1'b1);
         tg += int'(drv[0] !== last);
         sh += int'(shoot === 1'b1);
         last = drv[0];
      end
   endtask

   // period value 4 gives 20 timer counts per period
   task automatic cfg(input logic [7:0] mode, input logic [9:0] duty, input logic [7:0] db,
                      input logic [1:0] ps, input logic [7:0] st, input int wait_n);
      apb(1'b1, OFS_PERIOD, 32'h4);
      apb(1'b1, OFS_PRESC, {30'h0, ps});
      apb(1'b1, OFS_DBCFG, {24'h0, db});
      apb(1'b1, OFS_STEER, {24'h0, st});
      apb(1'b1, OFS_DUTY, {24'h0, duty[9:2]});
      apb(1'b1, OFS_MODE, {24'h0, mode[7:6], duty[1:0], mode[3:0]});
      repeat (wait_n) @(posedge pclk);
   endtask

   task automatic t_reset();
      apb(1'b0, OFS_STEER, 32'h0);
      check(rd, 32'h01, "steering reset");
      apb(1'b0, OFS_PERIOD, 32'h0);
      check(rd, 32'hFF, "period reset");
      check({28'h0, en}, 32'h0, "idle drive");
      apb(1'b1, 8'h40, 32'hFFFF);
      check({31'h0, err}, 32'h1, "unmapped write");
      apb(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_single();
      // the power-on period of 1024 timer counts must end before any setting loads
      cfg(8'h0C, 10'h8, 8'h0, 2'h0, 8'h01, 1100);
      measure(40);
      check(hc[0], 16, "single duty");
      check({28'h0, en}, 32'h1, "single drive");
      apb(1'b1, OFS_STEER, 32'h02);
      repeat (4) @(posedge pclk);
      check({28'h0, en}, 32'h2, "steer at once");
      measure(40);
      check(hc[1], 16, "steered to b");
      cfg(8'h0D, 10'h8, 8'h0, 2'h0, 8'h1F, 60);
      measure(40);
      check({hc[0][7:0], hc[1][7:0], hc[2][7:0], hc[3][7:0]}, 32'h10181018, "polarity");
      check({28'h0, en}, 32'hF, "all steered");
      cfg(8'h0C, 10'h3FF, 8'h0, 2'h0, 8'h01, 60);
      measure(40);
      check(tg, 0, "duty over period");
      $display("test single and steering done");
   endtask

   task automatic t_half();
      int t [3][4] = '{'{8, 1, 8, 16}, '{8, 3, 0, 0}, '{12, 2, 8, 0}};
      for (int k = 0; k < 3; k++)
      begin
         cfg(8'h8C, t[k][0], t[k][1], 2'h0, 8'h0F, 60);
         measure(40);
         check(hc[0], t[k][2], "half a");
         check(hc[1], t[k][3], "half b");
         check(sh, 0, "leg overlap");
         check({28'h0, en}, 32'h3, "half pins");
      end
      $display("test half bridge done");
   endtask

   task automatic t_full();
      logic [7:0] m [2] = '{8'h4C, 8'hCC};
      logic [31:0] e [2] = '{32'h28000010, 32'h00102800};
      for (int k = 0; k < 2; k++)
      begin
         cfg(m[k], 10'h8, 8'h05, 2'h0, 8'h01, 60);
         measure(40);
         check({hc[0][7:0], hc[1][7:0], hc[2][7:0], hc[3][7:0]}, e[k], "full");
         check(sh, 0, "leg overlap");
      end
      $display("test full bridge done");
   endtask

   // duty kept well below full before each reversal
   task automatic t_dir();
      int mult [3] = '{1, 4, 16};
      int n;
      for (int k = 0; k < 3; k++)
      begin
         cfg(8'h4C, 10'h8, 8'h0, k[1:0], 8'h01, 60 * mult[k]);
         // write the reversal just after a period starts, clear of the switch window
         n = 0;
         while (drv[3] !== 1'b0 && n < 1000)
         begin
            @(posedge pclk);
            n++;
         end
         while (drv[3] !== 1'b1 && n < 1000)
         begin
            @(posedge pclk);
            n++;
         end
         apb(1'b1, OFS_MODE, 32'hCC);
         n = 0;
         while (drv[0] !== 1'b0 && n < 1000)
         begin
            @(posedge pclk);
            n++;
         end
         check({29'h0, drv[3:1]}, 32'h2, "early switch");
         n = 0;
         while (drv[1] !== 1'b1 && n < 1000)
         begin
            @(posedge pclk);
            n++;
         end
         check(n, 4 * mult[k], "switch lead");
         measure(40 * mult[k]);
         check(hc[2], 40 * mult[k], "new direction");
      end
      $display("test direction change done");
   endtask

   task automatic t_shut();
      // the slow period left by the direction test must end before steering loads
      cfg(8'h0C, 10'h8, 8'h0, 2'h0, 8'h11, 400);
      apb(1'b1, OFS_SDCFG, 32'h44);
      shutdown_in <= 1'b1;
      repeat (4) @(posedge pclk);
      measure(40);
      check(hc[0], 40, "shutdown level");
      check({31'h0, en[1]}, 32'h0, "unsteered pin");
      shutdown_in <= 1'b0;
      apb(1'b1, OFS_SDCFG, 32'h0);
      $display("test shutdown done");
   endtask

   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_single();
      t_half();
      t_full();
      t_dir();
      t_shut();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
